// >>> rtl/dsadc_pkg.sv
// Shared phase codes, counts and widths for the dual-slope converter link.
package dsadc_pkg;
	// ----------------------------------------------------------------
	// Phase encoding (first bit, second bit)
	// ----------------------------------------------------------------
	typedef enum logic [1:0] {
		PH_ZERO_INTEG = 2'h0,
		PH_AUTOZERO = 2'h1,
		PH_SIG_INTEG = 2'h2,
		PH_DEINTEG = 2'h3
	} phase_t;
	// ----------------------------------------------------------------
	// Counter and divider sizes, default counts
	// ----------------------------------------------------------------
	localparam int DIV_W = 16;
	localparam int CNT_W = 16;
	localparam logic [DIV_W-1:0] DIV_RESET = 16'h0032;
	localparam logic [CNT_W-1:0] AZ_COUNT_RESET = 16'h0800;
	localparam logic [CNT_W-1:0] SI_COUNT_RESET = 16'h0800;
	localparam logic [CNT_W-1:0] DI_COUNT_RESET = 16'h1000;
	localparam logic [CNT_W-1:0] ZI_COUNT_RESET = 16'h0199;
	// ----------------------------------------------------------------
	// Software port register offsets
	// ----------------------------------------------------------------
	localparam logic [3:0] REG_CTRL = 4'h0;
	localparam logic [3:0] REG_DIV = 4'h1;
	localparam logic [3:0] REG_AZ_CNT = 4'h2;
	localparam logic [3:0] REG_SI_CNT = 4'h3;
	localparam logic [3:0] REG_DI_CNT = 4'h4;
	localparam logic [3:0] REG_ZI_CNT = 4'h5;
	localparam logic [3:0] REG_STATUS = 4'h6;
	localparam logic [3:0] REG_RESULT = 4'h7;
	localparam logic [3:0] REG_COUNT = 4'h8;
	// Control register bits.
	localparam int CTRL_START_BIT = 0;
	localparam int CTRL_CONT_BIT = 1;
	localparam int CTRL_ZI_BIT = 2;
	// Status register bits.
	localparam int ST_BUSY_BIT = 0;
	localparam int ST_DONE_BIT = 1;
	localparam int ST_POL_BIT = 2;
	localparam int ST_OVR_BIT = 3;
endpackage : dsadc_pkg

// >>> rtl/dsadc_link_if.sv
// Interface joining the converter control end and the host end.
`timescale 1ns/1ps
`default_nettype none
interface dsadc_link_if;
	import dsadc_pkg::*;
	logic [1:0] phase;
	logic comp_out;
	modport converter (input phase, output comp_out);
	modport host (output phase, input comp_out);
endinterface : dsadc_link_if
`default_nettype wire

// >>> rtl/dsadc_converter.sv
// Converter end: phase decode, switch control and comparator output logic.
`timescale 1ns/1ps
`default_nettype none
module dsadc_converter
	import dsadc_pkg::*;
(
	// Clock and control
	input wire logic mclk_i,
	input wire logic rst_i,
	input wire logic ce_i,
	// Link to host
	dsadc_link_if.converter link,
	// Analog front end
	input wire logic integ_positive_i,
	output logic input_switch_o,
	output logic ref_pos_switch_o,
	output logic ref_neg_switch_o,
	output logic autozero_switch_o,
	output logic ref_cap_charge_switch_o,
	output logic feedback_switch_o,
	output logic integ_zero_switch_o
);
	// ----------------------------------------------------------------
	// Input synchronisers
	// ----------------------------------------------------------------
	logic [1:0] ph_meta_ff, ph_ff;
	logic pol_meta_ff, pol_ff;
	logic in_deint_ff;
	logic latch_pos_ff;
	always_ff @(posedge mclk_i) begin
		if (rst_i) begin
			ph_meta_ff <= 2'h0;
			ph_ff <= 2'h0;
			pol_meta_ff <= 1'b0;
			pol_ff <= 1'b0;
		end else if (ce_i) begin
			ph_meta_ff <= link.phase;
			ph_ff <= ph_meta_ff;
			pol_meta_ff <= integ_positive_i;
			pol_ff <= pol_meta_ff;
		end
	end
	// ----------------------------------------------------------------
	// Polarity latch on deintegrate entry
	// ----------------------------------------------------------------
	// The latch is what makes the zero crossing always a falling edge,
	// even if polarity flipped while the host was sampling it.
	always_ff @(posedge mclk_i) begin
		if (rst_i) begin
			in_deint_ff <= 1'b0;
			latch_pos_ff <= 1'b0;
		end else if (ce_i) begin
			in_deint_ff <= (phase_t'(ph_ff) == PH_DEINTEG);
			if (phase_t'(ph_ff) == PH_DEINTEG && !in_deint_ff)
				latch_pos_ff <= pol_ff;
		end
	end
	// ----------------------------------------------------------------
	// Switch matrix and comparator pin
	// ----------------------------------------------------------------
	logic nxt_comp;
	logic deint_now;
	assign deint_now = (phase_t'(ph_ff) == PH_DEINTEG);
	always_comb begin
		// Before deintegrate the pin reports raw polarity; on the latching cycle it is driven high.
		if (deint_now && in_deint_ff)
			nxt_comp = pol_ff ^ ~latch_pos_ff;
		else if (deint_now)
			nxt_comp = 1'b1;
		else
			nxt_comp = pol_ff;
	end
	always_ff @(posedge mclk_i) begin
		if (rst_i) begin
			link.comp_out <= 1'b0;
			input_switch_o <= 1'b0;
			ref_pos_switch_o <= 1'b0;
			ref_neg_switch_o <= 1'b0;
			autozero_switch_o <= 1'b0;
			ref_cap_charge_switch_o <= 1'b0;
			feedback_switch_o <= 1'b0;
			integ_zero_switch_o <= 1'b0;
		end else if (ce_i) begin
			link.comp_out <= nxt_comp;
			input_switch_o <= 1'b0;
			ref_pos_switch_o <= 1'b0;
			ref_neg_switch_o <= 1'b0;
			autozero_switch_o <= 1'b0;
			ref_cap_charge_switch_o <= 1'b0;
			feedback_switch_o <= 1'b0;
			integ_zero_switch_o <= 1'b0;
			unique case (phase_t'(ph_ff))
				PH_ZERO_INTEG: begin
					feedback_switch_o <= 1'b1;
					integ_zero_switch_o <= 1'b1;
				end
				PH_AUTOZERO: begin
					autozero_switch_o <= 1'b1;
					ref_cap_charge_switch_o <= 1'b1;
					feedback_switch_o <= 1'b1;
				end
				PH_SIG_INTEG: begin
					input_switch_o <= 1'b1;
				end
				PH_DEINTEG: begin
					feedback_switch_o <= 1'b1;
					if (in_deint_ff) begin
						ref_pos_switch_o <= latch_pos_ff;
						ref_neg_switch_o <= ~latch_pos_ff;
					end
				end
			endcase
		end
	end
endmodule : dsadc_converter
`default_nettype wire

// >>> rtl/dsadc_clock_divider.sv
// Free-running divider that makes the square-wave conversion clock.
`timescale 1ns/1ps
`default_nettype none
module dsadc_clock_divider
	import dsadc_pkg::*;
(
	// Clock and control
	input wire logic mclk_i,
	input wire logic rst_i,
	input wire logic ce_i,
	// Divider constant
	input wire logic [DIV_W-1:0] div_i,
	// Square wave and its falling-edge strobe
	output logic conv_clock_out_o,
	output logic fall_o
);
	logic [DIV_W-1:0] cnt_ff;
	// A zero constant is treated as one so the clock never stops.
	always_ff @(posedge mclk_i) begin
		if (rst_i) begin
			cnt_ff <= '0;
			conv_clock_out_o <= 1'b0;
			fall_o <= 1'b0;
		end else if (ce_i) begin
			fall_o <= 1'b0;
			if (cnt_ff == 16'h0000) begin
				cnt_ff <= (div_i == 16'h0000) ? 16'h0000 : div_i - 16'h0001;
				conv_clock_out_o <= ~conv_clock_out_o;
				fall_o <= conv_clock_out_o;
			end else begin
				cnt_ff <= cnt_ff - 16'h0001;
			end
		end
	end
endmodule : dsadc_clock_divider
`default_nettype wire

// >>> rtl/dsadc_host.sv
// Host end: phase sequencer, measurement counter and software register port.
//
// Operation
// - Two phase bits select converter phase.
// - Comparator goes high entering deintegrate.
// - Zero crossing is always a falling edge.
// - Comparator shows polarity during signal integrate.
// - Polarity stays valid until deintegrate.
// - Late polarity change still toggles at deintegrate.
// - Reference switch follows latched polarity.
// - Zero-integrator actively drives integrator to zero.
// - Zero-integrator always followed by autozero.
// - After overrange, short zero-integrator before autozero.
// - Host polls or interrupts on comparator.
// - Conversion clock from 16-bit free-running divider.
// - Divider constant sets speed and rejection.
// - Counter decrements on conversion clock falling edge.
// - Counter underflow flags end of phase.
// - Capture count when comparator falls.
// - Start value sets resolution.
// - Counts programmable for 8 to 14 bits.
// - Polarity latched; inverted latch XOR comparator.
// - 12-bit: 2048, 2048, then 4096 counts.
// - Only first falling edge captures the result.
`timescale 1ns/1ps
`default_nettype none
module dsadc_host
	import dsadc_pkg::*;
(
	// Clock and control
	input wire logic mclk_i,
	input wire logic rst_i,
	input wire logic ce_i,
	// Software port
	input wire logic [3:0] addr_i,
	input wire logic [31:0] wdata_i,
	input wire logic wr_i,
	input wire logic rd_i,
	output logic [31:0] rdata_o,
	// Event output
	output logic done_o,
	// Link to converter
	dsadc_link_if.host link,
	// Conversion clock pin
	output logic conv_clock_out_o
);
	// ----------------------------------------------------------------
	// Configuration registers
	// ----------------------------------------------------------------
	logic [DIV_W-1:0] div_ff;
	logic [CNT_W-1:0] az_cnt_ff, si_cnt_ff, di_cnt_ff, zi_cnt_ff;
	logic cont_ff, zi_en_ff, start_ff;
	always_ff @(posedge mclk_i) begin
		if (rst_i) begin
			div_ff <= DIV_RESET;
			az_cnt_ff <= AZ_COUNT_RESET;
			si_cnt_ff <= SI_COUNT_RESET;
			di_cnt_ff <= DI_COUNT_RESET;
			zi_cnt_ff <= ZI_COUNT_RESET;
			cont_ff <= 1'b0;
			zi_en_ff <= 1'b0;
			start_ff <= 1'b0;
		end else if (ce_i) begin
			start_ff <= wr_i && addr_i == REG_CTRL && wdata_i[CTRL_START_BIT];
			if (wr_i) begin
				unique case (addr_i)
					REG_CTRL: begin
						cont_ff <= wdata_i[CTRL_CONT_BIT];
						zi_en_ff <= wdata_i[CTRL_ZI_BIT];
					end
					REG_DIV: div_ff <= wdata_i[DIV_W-1:0];
					REG_AZ_CNT: az_cnt_ff <= wdata_i[CNT_W-1:0];
					REG_SI_CNT: si_cnt_ff <= wdata_i[CNT_W-1:0];
					REG_DI_CNT: di_cnt_ff <= wdata_i[CNT_W-1:0];
					REG_ZI_CNT: zi_cnt_ff <= wdata_i[CNT_W-1:0];
					default: ;
				endcase
			end
		end
	end
	// ----------------------------------------------------------------
	// Conversion clock
	// ----------------------------------------------------------------
	logic count_pulse_in;
	dsadc_clock_divider u_div (
		.mclk_i(mclk_i),
		.rst_i(rst_i),
		.ce_i(ce_i),
		.div_i(div_ff),
		.conv_clock_out_o(conv_clock_out_o),
		.fall_o(count_pulse_in)
	);
	// ----------------------------------------------------------------
	// Comparator synchroniser and edge detect
	// ----------------------------------------------------------------
	logic comp_meta_ff, comp_sync_ff, comp_prev_ff;
	always_ff @(posedge mclk_i) begin
		if (rst_i) begin
			comp_meta_ff <= 1'b0;
			comp_sync_ff <= 1'b0;
			comp_prev_ff <= 1'b0;
		end else if (ce_i) begin
			comp_meta_ff <= link.comp_out;
			comp_sync_ff <= comp_meta_ff;
			comp_prev_ff <= comp_sync_ff;
		end
	end
	logic comp_fall;
	assign comp_fall = comp_prev_ff && !comp_sync_ff;
	// ----------------------------------------------------------------
	// Phase sequencer and measurement counter
	// ----------------------------------------------------------------
	typedef enum logic [2:0] {S_IDLE, S_ZI, S_AZ, S_SI, S_DI} seq_t;
	seq_t state_ff;
	logic [CNT_W-1:0] phase_cnt_ff, result_ff;
	logic underflow;
	logic crossed_ff, pol_ff, ovr_ff, busy, done_ff;
	// Phase change waits for the falling edge so whole counts are kept.
	assign underflow = count_pulse_in && phase_cnt_ff == '0;
	always_ff @(posedge mclk_i) begin
		if (rst_i) begin
			state_ff <= S_IDLE;
			phase_cnt_ff <= '0;
			link.phase <= PH_ZERO_INTEG;
			crossed_ff <= 1'b0;
			result_ff <= '0;
			pol_ff <= 1'b0;
			ovr_ff <= 1'b0;
			done_o <= 1'b0;
		end else if (ce_i) begin
			done_o <= 1'b0;
			if (count_pulse_in && phase_cnt_ff != '0)
				phase_cnt_ff <= phase_cnt_ff - 16'h0001;
			unique case (state_ff)
				S_IDLE: if (start_ff) begin
					// Overrange recovery goes through zero-integrator first.
					if (zi_en_ff && ovr_ff) begin
						state_ff <= S_ZI;
						link.phase <= PH_ZERO_INTEG;
						phase_cnt_ff <= zi_cnt_ff;
					end else begin
						state_ff <= S_AZ;
						link.phase <= PH_AUTOZERO;
						phase_cnt_ff <= az_cnt_ff;
					end
				end
				S_ZI: if (underflow) begin
					state_ff <= S_AZ;
					link.phase <= PH_AUTOZERO;
					phase_cnt_ff <= az_cnt_ff;
				end
				S_AZ: if (underflow) begin
					state_ff <= S_SI;
					link.phase <= PH_SIG_INTEG;
					phase_cnt_ff <= si_cnt_ff;
				end
				S_SI: if (underflow) begin
					pol_ff <= comp_sync_ff;
					crossed_ff <= 1'b0;
					state_ff <= S_DI;
					link.phase <= PH_DEINTEG;
					phase_cnt_ff <= di_cnt_ff;
				end
				S_DI: begin
					if (comp_fall && !crossed_ff) begin
						crossed_ff <= 1'b1;
						result_ff <= di_cnt_ff - phase_cnt_ff;
					end
					if (underflow) begin
						ovr_ff <= !(crossed_ff || comp_fall);
						done_o <= 1'b1;
						link.phase <= PH_ZERO_INTEG;
						if (cont_ff) begin
							if (zi_en_ff && !(crossed_ff || comp_fall)) begin
								state_ff <= S_ZI;
								phase_cnt_ff <= zi_cnt_ff;
							end else begin
								state_ff <= S_AZ;
								link.phase <= PH_AUTOZERO;
								phase_cnt_ff <= az_cnt_ff;
							end
						end else begin
							state_ff <= S_IDLE;
						end
					end
				end
			endcase
		end
	end
	// ----------------------------------------------------------------
	// Sticky done flag and read port
	// ----------------------------------------------------------------
	logic rd_status;
	assign rd_status = rd_i && addr_i == REG_STATUS;
	always_ff @(posedge mclk_i) begin
		if (rst_i)
			done_ff <= 1'b0;
		else if (ce_i) begin
			// A completion in the clearing cycle survives the read.
			if (done_o)
				done_ff <= 1'b1;
			else if (rd_status)
				done_ff <= 1'b0;
		end
	end
	always_ff @(posedge mclk_i) begin
		if (rst_i)
			rdata_o <= '0;
		else if (ce_i) begin
			rdata_o <= '0;
			if (rd_i) begin
				unique case (addr_i)
					REG_CTRL: rdata_o <= {29'h0, zi_en_ff, cont_ff, 1'b0};
					REG_DIV: rdata_o <= {16'h0, div_ff};
					REG_AZ_CNT: rdata_o <= {16'h0, az_cnt_ff};
					REG_SI_CNT: rdata_o <= {16'h0, si_cnt_ff};
					REG_DI_CNT: rdata_o <= {16'h0, di_cnt_ff};
					REG_ZI_CNT: rdata_o <= {16'h0, zi_cnt_ff};
					REG_STATUS: rdata_o <= {28'h0, ovr_ff, pol_ff, done_ff, busy};
					REG_RESULT: rdata_o <= {16'h0, result_ff};
					REG_COUNT: rdata_o <= {16'h0, phase_cnt_ff};
					default: rdata_o <= '0;
				endcase
			end
		end
	end
	assign busy = (state_ff != S_IDLE);
endmodule : dsadc_host
`default_nettype wire

// >>> dv/dsadc_link_chk.sv
// Checker for the converter link: phase order, switch decode and comparator framing.
`timescale 1ns/1ps
`default_nettype none
module dsadc_link_chk
	import dsadc_pkg::*;
(
	// Clock and reset
	input wire logic mclk_i,
	input wire logic rst_i,
	// Link and front end
	input wire logic [1:0] phase,
	input wire logic comp_out,
	input wire logic integ_positive_i,
	input wire logic input_switch_o,
	input wire logic ref_pos_switch_o,
	input wire logic ref_neg_switch_o,
	input wire logic autozero_switch_o,
	input wire logic ref_cap_charge_switch_o,
	input wire logic feedback_switch_o,
	input wire logic integ_zero_switch_o
);
	default clocking cb @(posedge mclk_i); endclocking
	default disable iff (rst_i);
	// ------------
	// Settling ages
	// ------------
	// Levels lag the phase through synchronisers, so checks wait for a settled phase.
	logic [1:0] phase_d_ff;
	logic integ_d_ff;
	logic [3:0] ph_age_ff;
	logic [3:0] in_age_ff;
	logic ph_set;
	logic in_set;
	always_ff @(posedge mclk_i) begin
		phase_d_ff <= rst_i ? 2'h0 : phase;
		integ_d_ff <= integ_positive_i;
	end
	always_ff @(posedge mclk_i) begin
		if (rst_i || phase != phase_d_ff) begin
			ph_age_ff <= 4'h0;
		end else if (ph_age_ff != 4'hf) begin
			ph_age_ff <= ph_age_ff + 4'h1;
		end
	end
	always_ff @(posedge mclk_i) begin
		if (rst_i || integ_positive_i != integ_d_ff) begin
			in_age_ff <= 4'h0;
		end else if (in_age_ff != 4'hf) begin
			in_age_ff <= in_age_ff + 4'h1;
		end
	end
	assign ph_set = phase == phase_d_ff && ph_age_ff >= 4'h6;
	assign in_set = integ_positive_i == integ_d_ff && in_age_ff >= 4'h6;
	// ------------
	// Properties
	// ------------
	property p_zi_next;
		phase_d_ff == PH_ZERO_INTEG && phase != phase_d_ff |-> phase == PH_AUTOZERO;
	endproperty
	a_zi_next: assert property (p_zi_next) else $error("bad phase after zero-int");
	property p_az_next;
		phase_d_ff == PH_AUTOZERO && phase != phase_d_ff |-> phase == PH_SIG_INTEG;
	endproperty
	a_az_next: assert property (p_az_next) else $error("bad phase after autozero");
	property p_si_next;
		phase_d_ff == PH_SIG_INTEG && phase != phase_d_ff |-> phase == PH_DEINTEG;
	endproperty
	a_si_next: assert property (p_si_next) else $error("bad phase after integrate");
	property p_di_high;
		phase_d_ff == PH_SIG_INTEG && phase == PH_DEINTEG |-> ##[1:4] comp_out;
	endproperty
	a_di_high: assert property (p_di_high) else $error("comparator not high in deint");
	property p_no_rise;
		phase == PH_DEINTEG && ph_set |-> !$rose(comp_out);
	endproperty
	a_no_rise: assert property (p_no_rise) else $error("rising comparator in deint");
	property p_si_pol;
		phase == PH_SIG_INTEG && ph_set && in_set |-> comp_out == integ_positive_i;
	endproperty
	a_si_pol: assert property (p_si_pol) else $error("polarity wrong in integrate");
	property p_zi_sw;
		phase == PH_ZERO_INTEG && ph_set |-> integ_zero_switch_o && feedback_switch_o
			&& !input_switch_o && !autozero_switch_o;
	endproperty
	a_zi_sw: assert property (p_zi_sw) else $error("zero-int switches wrong");
	property p_az_sw;
		phase == PH_AUTOZERO && ph_set |-> autozero_switch_o && ref_cap_charge_switch_o
			&& feedback_switch_o && !integ_zero_switch_o && !input_switch_o;
	endproperty
	a_az_sw: assert property (p_az_sw) else $error("autozero switches wrong");
	property p_si_sw;
		phase == PH_SIG_INTEG && ph_set |-> input_switch_o && !feedback_switch_o
			&& !ref_pos_switch_o && !ref_neg_switch_o;
	endproperty
	a_si_sw: assert property (p_si_sw) else $error("integrate switches wrong");
	property p_di_sw;
		phase == PH_DEINTEG && ph_set |-> feedback_switch_o && !input_switch_o
			&& (ref_pos_switch_o ^ ref_neg_switch_o);
	endproperty
	a_di_sw: assert property (p_di_sw) else $error("deint switches wrong");
	c_fall: cover property (phase == PH_DEINTEG && $fell(comp_out));
	c_zi: cover property (phase == PH_ZERO_INTEG && integ_zero_switch_o);
	c_neg: cover property (phase == PH_DEINTEG && ref_neg_switch_o);
endmodule : dsadc_link_chk
`default_nettype wire

// >>> dv/dual_slope_adc_phase_control_tb.sv
// Testbench joining both link ends, driven through the host software port.
`timescale 1ns/1ps
`default_nettype none
module dual_slope_adc_phase_control_tb
	import dsadc_pkg::*;
;
	logic mclk_i = 1'b0;
	logic rst_i = 1'b1;
	logic ce_i = 1'b1;
	logic [3:0] addr_i = 4'h0;
	logic [31:0] wdata_i = 32'h0;
	logic wr_i = 1'b0;
	logic rd_i = 1'b0;
	logic integ_positive_i = 1'b0;
	logic [31:0] rdata_o;
	logic [31:0] v;
	logic done_o, conv_clock_out_o, input_switch_o, ref_pos_switch_o, ref_neg_switch_o;
	logic autozero_switch_o, ref_cap_charge_switch_o, feedback_switch_o, integ_zero_switch_o;
	int failures = 0;
	int n_checks = 0;
	logic [3:0] ra [8] = '{REG_CTRL, REG_DIV, REG_AZ_CNT, REG_SI_CNT, REG_DI_CNT, REG_ZI_CNT,
		REG_STATUS, 4'hf};
	logic [31:0] rv [8] = '{32'h0, 32'h32, 32'h800, 32'h800, 32'h1000, 32'h199, 32'h0, 32'h0};
	logic [31:0] cv [6] = '{32'h0, 32'h0, 32'h4, 32'h4, 32'h14, 32'h6};
	always #5 mclk_i = ~mclk_i;
	dsadc_link_if u_dsadc_link_if();
	dsadc_converter u_dsadc_converter(.mclk_i(mclk_i), .rst_i(rst_i), .ce_i(ce_i),
		.link(u_dsadc_link_if.converter), .integ_positive_i(integ_positive_i),
		.input_switch_o(input_switch_o), .ref_pos_switch_o(ref_pos_switch_o),
		.ref_neg_switch_o(ref_neg_switch_o), .autozero_switch_o(autozero_switch_o),
		.ref_cap_charge_switch_o(ref_cap_charge_switch_o),
		.feedback_switch_o(feedback_switch_o), .integ_zero_switch_o(integ_zero_switch_o));
	dsadc_host u_dsadc_host(.mclk_i(mclk_i), .rst_i(rst_i), .ce_i(ce_i), .addr_i(addr_i),
		.wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .done_o(done_o),
		.link(u_dsadc_link_if.host), .conv_clock_out_o(conv_clock_out_o));
	dsadc_link_chk u_dsadc_link_chk(.mclk_i(mclk_i), .rst_i(rst_i),
		.phase(u_dsadc_link_if.phase), .comp_out(u_dsadc_link_if.comp_out),
		.integ_positive_i(integ_positive_i), .input_switch_o(input_switch_o),
		.ref_pos_switch_o(ref_pos_switch_o), .ref_neg_switch_o(ref_neg_switch_o),
		.autozero_switch_o(autozero_switch_o), .ref_cap_charge_switch_o(ref_cap_charge_switch_o),
		.feedback_switch_o(feedback_switch_o), .integ_zero_switch_o(integ_zero_switch_o));
	// ------------
	// Tasks
	// ------------
	task automatic end_sim;
		if (failures == 0 && n_checks > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask : end_sim
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		n_checks++;
		if (seen !== exp) begin
			failures++;
			$display("mismatch at %0t: got %h want %h", $time, seen, exp);
		end
	endtask : chk
	// Each access ends one edge late so back-to-back calls never reassign a strobe.
	task automatic wr(input logic [3:0] a, input logic [31:0] d);
		addr_i <= a;
		wdata_i <= d;
		wr_i <= 1'b1;
		@(posedge mclk_i);
		wr_i <= 1'b0;
		@(posedge mclk_i);
	endtask : wr
	task automatic rd(input logic [3:0] a, output logic [31:0] d);
		addr_i <= a;
		rd_i <= 1'b1;
		@(posedge mclk_i);
		rd_i <= 1'b0;
		@(negedge mclk_i);
		d = rdata_o;
		@(posedge mclk_i);
	endtask : rd
	task automatic wait_ph(input phase_t p);
		for (int i = 0; i < 300 && u_dsadc_link_if.phase !== p; i++) @(negedge mclk_i);
		chk(32'(u_dsadc_link_if.phase), 32'(p));
	endtask : wait_ph
	task automatic hp(output logic [31:0] n);
		n = 0;
		for (int i = 0; i < 100 && conv_clock_out_o !== 1'b0; i++) @(negedge mclk_i);
		for (int i = 0; i < 100 && conv_clock_out_o !== 1'b1; i++) @(negedge mclk_i);
		while (n < 50 && conv_clock_out_o === 1'b1) begin
			n++;
			@(negedge mclk_i);
		end
		@(posedge mclk_i);
	endtask : hp
	task automatic conv(input logic pos, input logic zi, input int flip);
		integ_positive_i <= pos;
		wr(REG_CTRL, {29'h0, zi, 2'h1});
		if (zi) begin
			wait_ph(PH_ZERO_INTEG);
			repeat (6) @(negedge mclk_i);
			chk(32'(integ_zero_switch_o), 32'h1);
			@(posedge mclk_i);
		end
		wait_ph(PH_AUTOZERO);
		wait_ph(PH_SIG_INTEG);
		wait_ph(PH_DEINTEG);
		repeat (8) @(negedge mclk_i);
		chk(32'(u_dsadc_link_if.comp_out), 32'h1);
		chk(32'(ref_pos_switch_o), 32'(pos));
		chk(32'(ref_neg_switch_o), 32'(!pos));
		repeat (flip) @(posedge mclk_i);
		if (flip > 0) integ_positive_i <= !pos;
		for (int i = 0; i < 400 && done_o !== 1'b1; i++) @(negedge mclk_i);
		chk(32'(done_o), 32'h1);
		@(negedge mclk_i);
		chk(32'(done_o), 32'h0);
		@(posedge mclk_i);
		rd(REG_STATUS, v);
		chk(v, {28'h0, flip == 0, pos, 2'h2});
		rd(REG_STATUS, v);
		chk(v, {28'h0, flip == 0, pos, 2'h0});
		rd(REG_COUNT, v);
		chk(v, 32'h0);
		if (flip > 0) begin
			rd(REG_RESULT, v);
			chk(32'(v >= (8 + flip) / 2 - 1 && v <= (16 + flip) / 2 + 2), 32'h1);
		end
	endtask : conv
	// ------------
	// Sequence
	// ------------
	initial begin
		#200000;
		failures++;
		end_sim();
	end
	initial begin
		repeat (8) @(posedge mclk_i);
		rst_i <= 1'b0;
		@(posedge mclk_i);
		for (int i = 0; i < 8; i++) begin
			rd(ra[i], v);
			chk(v, rv[i]);
		end
		wr(4'hf, 32'h5a);
		rd(4'hf, v);
		chk(v, 32'h0);
		for (int i = 2; i < 6; i++) begin
			wr(ra[i], cv[i]);
			rd(ra[i], v);
			chk(v, cv[i]);
		end
		wr(REG_DIV, 32'h3);
		hp(v);
		chk(v, 32'h3);
		wr(REG_DIV, 32'h5);
		hp(v);
		chk(v, 32'h5);
		wr(REG_DIV, 32'h1);
		// A low enable must freeze the divider even at its fastest setting.
		ce_i <= 1'b0;
		@(posedge mclk_i);
		v = {31'h0, conv_clock_out_o};
		repeat (10) @(posedge mclk_i);
		chk(32'(conv_clock_out_o), v);
		ce_i <= 1'b1;
		@(posedge mclk_i);
		conv(1'b1, 1'b0, 8);
		conv(1'b0, 1'b0, 8);
		conv(1'b1, 1'b0, 0);
		conv(1'b0, 1'b1, 8);
		end_sim();
	end
endmodule : dual_slope_adc_phase_control_tb
`default_nettype wire
